// ===== bench/mic_core_model.sv
// Purpose: core model issuing machine cycles, instruction ends, returns
// Assumes: four clocks per instruction, one machine cycle each
// Notes:   a return asked for by the bench runs as the next instruction
`timescale 1ns/1ps
module mic_core_model (
	input  wire logic          clk,
	input  wire logic          nrst,
	input  wire logic          return_from_interrupt_go,
	output mic_pkg::mic_core_t core
);
	logic [1:0] cnt_r;
	logic [1:0] cnt_nxt;
	logic       return_from_interrupt_r;
	logic       return_from_interrupt_nxt;

	always_comb begin
		cnt_nxt  = cnt_r + 2'h1;
		// latched at the end edge so a return never starts mid-instruction
		return_from_interrupt_nxt = (cnt_r == 2'h3) ? return_from_interrupt_go : return_from_interrupt_r;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_r  <= 2'h0;
			return_from_interrupt_r <= 1'b0;
		end else begin
			cnt_r  <= cnt_nxt;
			return_from_interrupt_r <= return_from_interrupt_nxt;
		end
	end

	assign core.mcycle    = (cnt_r == 2'h1);
	assign core.instr_end = (cnt_r == 2'h3);
	assign core.is_return_from_interrupt   = return_from_interrupt_r;
endmodule

// ===== bench/tb_mic_intc.sv
// Purpose: self-checking bench for the interrupt controller
// Assumes: core model ends an instruction every four clocks
// Notes:   inputs move 1 ns after the rising edge
`timescale 1ns/1ps
module tb_mic_intc;
	logic                  clk = 1'b0;
	logic                  nrst = 1'b0;
	logic                  sync_clr = 1'b0;
	logic                  return_from_interrupt_go = 1'b0;
	logic                  ext0_pin = 1'b1;
	logic                  ext1_pin = 1'b1;
	mic_pkg::mic_sfr_req_t sfr = '0;
	mic_pkg::mic_io_req_t  io = '0;
	mic_pkg::mic_src_t     src = '0;
	mic_pkg::mic_core_t    core;
	logic                  irq_call;
	logic [15:0]           irq_vector;
	logic                  t0_ack;
	logic                  t1_ack;
	logic [7:0]            sfr_rdata;
	logic [7:0]            io_rdata;
	int                    failures = 0;
	int                    num_checks = 0;
	int                    cycles = 0;
	logic [7:0]            regs [11] = '{mic_pkg::SFR_TIMER_EXT_INT_CONTROL,
		mic_pkg::SFR_INT_ENABLE_SECOND_SERIAL, mic_pkg::SFR_INT_ENABLE_PRIMARY, mic_pkg::SFR_IP0,
		mic_pkg::SFR_INT_ENABLE_EXTERNAL_HIGH, mic_pkg::SFR_IP1, mic_pkg::SFR_EXT_INT_REQUEST_FLAGS,
		mic_pkg::SFR_EDGE_POLARITY_CONTROL, mic_pkg::SFR_SUBF_A, mic_pkg::SFR_SUBF_B, 8'h90};

	always #2.5 clk = ~clk;

	mic_core_model mic_core_model_i (.clk(clk), .nrst(nrst),
		.return_from_interrupt_go(return_from_interrupt_go), .core(core));

	mic_intc mic_intc_i (.clk(clk), .nrst(nrst), .sync_clr(sync_clr),
		.sfr(sfr), .io(io), .core(core), .src(src), .ext0_pin(ext0_pin),
		.ext1_pin(ext1_pin), .irq_call(irq_call), .irq_vector(irq_vector),
		.timer0_service_ack(t0_ack), .timer1_service_ack(t1_ack),
		.sfr_rdata(sfr_rdata), .io_rdata(io_rdata));

	task automatic complete_run();
		if (failures == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk(input string n, input logic [15:0] e,
		input logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) begin
			@(posedge clk);
			#1;
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sfr = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		tick(1);
		sfr = '0;
		tick(1);
	endtask

	task automatic rd_chk(input string n, input logic [7:0] a,
		input logic [7:0] e);
		sfr = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		tick(1);
		sfr = '0;
		chk(n, {8'h00, e}, {8'h00, sfr_rdata});
		tick(1);
	endtask

	task automatic no_call(input int n);
		repeat (n) begin
			tick(1);
			chk("no call", 16'h0000, {15'h0000, irq_call});
		end
	endtask

	task automatic call_chk(input logic [15:0] v, input logic a0,
		input logic a1);
		for (int i = 0; i < 40 && irq_call !== 1'b1; i++) begin
			tick(1);
		end
		chk("irq_call", 16'h0001, {15'h0000, irq_call});
		chk("irq_vector", v, irq_vector);
		chk("timer0 ack", {15'h0000, a0}, {15'h0000, t0_ack});
		chk("timer1 ack", {15'h0000, a1}, {15'h0000, t1_ack});
		tick(1);
	endtask

	task automatic do_return_from_interrupt();
		return_from_interrupt_go = 1'b1;
		for (int i = 0; i < 8 && core.instr_end !== 1'b1; i++) begin
			tick(1);
		end
		tick(1);
		return_from_interrupt_go = 1'b0;
		tick(1);
	endtask

	// hang guard, the whole sequence needs well under a thousand cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			complete_run();
		end
	end

	initial begin
		src.raw[6] = 1'b1;
		tick(4);
		nrst = 1'b1;
		foreach (regs[i]) rd_chk("reset value", regs[i], 8'h00);
		wr(mic_pkg::SFR_EDGE_POLARITY_CONTROL, 8'h00);
		wr(mic_pkg::SFR_IP0, 8'h08);
		wr(mic_pkg::SFR_IP1, 8'h08);
		src.timer0_ovf = 1'b1;
		src.compute_busy = 1'b1;
		ext1_pin = 1'b0;
		tick(1);
		src.timer0_ovf = 1'b0;
		src.compute_busy = 1'b0;
		tick(8);
		ext1_pin = 1'b1;
		no_call(12);
		rd_chk("timer_ext_int_control", mic_pkg::SFR_TIMER_EXT_INT_CONTROL, 8'h28);
		rd_chk("ext_int_request_flags", mic_pkg::SFR_EXT_INT_REQUEST_FLAGS, 8'h04);
		wr(mic_pkg::SFR_INT_ENABLE_PRIMARY, 8'h02);
		no_call(20);
		wr(mic_pkg::SFR_INT_ENABLE_PRIMARY, 8'h8a);
		call_chk(16'h000b, 1'b1, 1'b0);
		rd_chk("timer_ext_int_control", mic_pkg::SFR_TIMER_EXT_INT_CONTROL, 8'h08);
		src.timer1_ovf = 1'b1;
		tick(1);
		src.timer1_ovf = 1'b0;
		call_chk(16'h001b, 1'b0, 1'b1);
		wr(mic_pkg::SFR_INT_ENABLE_EXTERNAL_HIGH, 8'h08);
		src.voltage_status = 3'h5;
		no_call(20);
		rd_chk("ext_int_request_flags", mic_pkg::SFR_EXT_INT_REQUEST_FLAGS, 8'h0c);
		do_return_from_interrupt();
		call_chk(16'h005b, 1'b0, 1'b0);
		rd_chk("ext_int_request_flags", mic_pkg::SFR_EXT_INT_REQUEST_FLAGS, 8'h04);
		do_return_from_interrupt();
		do_return_from_interrupt();
		io = '{wr: 1'b1, rd: 1'b0, addr: mic_pkg::IO_SUBEN_A, wdata: 8'h01};
		tick(1);
		io = '{wr: 1'b0, rd: 1'b1, addr: mic_pkg::IO_SUBEN_A, wdata: 8'h00};
		tick(1);
		io = '0;
		chk("sub enable", 16'h0001, {8'h00, io_rdata});
		wr(mic_pkg::SFR_INT_ENABLE_EXTERNAL_HIGH, 8'h28);
		src.raw[6] = 1'b0;
		call_chk(16'h006b, 1'b0, 1'b0);
		rd_chk("sub flags", mic_pkg::SFR_SUBF_A, 8'h01);
		wr(mic_pkg::SFR_SUBF_A, 8'hff);
		rd_chk("sub flags", mic_pkg::SFR_SUBF_A, 8'h01);
		wr(mic_pkg::SFR_SUBF_A, 8'hfe);
		rd_chk("sub flags", mic_pkg::SFR_SUBF_A, 8'h00);
		// pulse sub-source feeds line 2; falling polarity fires on its clear
		io = '{wr: 1'b1, rd: 1'b0, addr: mic_pkg::IO_SUBEN_A, wdata: 8'h41};
		tick(1);
		io = '0;
		src.raw[0] = 1'b1;
		tick(1);
		src.raw[0] = 1'b0;
		tick(2);
		rd_chk("sub flags", mic_pkg::SFR_SUBF_A, 8'h40);
		wr(mic_pkg::SFR_SUBF_A, 8'hbf);
		tick(2);
		rd_chk("ext_int_request_flags", mic_pkg::SFR_EXT_INT_REQUEST_FLAGS, 8'h06);
		// edge mode: a pin held low sets the flag once only
		wr(mic_pkg::SFR_TIMER_EXT_INT_CONTROL, 8'h01);
		ext0_pin = 1'b0;
		tick(8);
		rd_chk("timer_ext_int_control", mic_pkg::SFR_TIMER_EXT_INT_CONTROL, 8'h03);
		wr(mic_pkg::SFR_TIMER_EXT_INT_CONTROL, 8'h01);
		rd_chk("timer_ext_int_control", mic_pkg::SFR_TIMER_EXT_INT_CONTROL, 8'h01);
		ext0_pin = 1'b1;
		sync_clr = 1'b1;
		tick(1);
		sync_clr = 1'b0;
		rd_chk("int_enable_primary", mic_pkg::SFR_INT_ENABLE_PRIMARY, 8'h00);
		complete_run();
	end
endmodule

// ===== hdl/mic_edge.sv
// Purpose: level tracking and edge detection for a bundle of lines
// Assumes: SYNC set for lines from pins, clear for on-chip logic
// Notes:   synced level moves only when the second and third stage agree
`timescale 1ns/1ps
module mic_edge #(
	parameter int W    = 1,
	parameter bit SYNC = 1'b0,
	parameter bit IDLE = 1'b0
) (
	input  wire logic [W-1:0] d,
	input  wire logic         clk,
	input  wire logic         nrst,
	output logic      [W-1:0] level,
	output logic      [W-1:0] rise,
	output logic      [W-1:0] fall
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	logic [W-1:0] lvl_r;
	logic [W-1:0] prev_r;
	logic [W-1:0] lvl_nxt;

	always_comb begin
		if (SYNC) begin
			lvl_nxt = (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & lvl_r);
		end else begin
			lvl_nxt = d;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s1_r   <= {W{IDLE}};
			s2_r   <= {W{IDLE}};
			s3_r   <= {W{IDLE}};
			lvl_r  <= {W{IDLE}};
			prev_r <= {W{IDLE}};
		end else begin
			s1_r   <= d;
			s2_r   <= s1_r;
			s3_r   <= s2_r;
			lvl_r  <= lvl_nxt;
			prev_r <= lvl_r;
		end
	end

	assign level = lvl_r;
	assign rise  = lvl_r & ~prev_r;
	assign fall  = ~lvl_r & prev_r;
endmodule

// ===== hdl/mic_intc.sv
// Purpose: interrupt controller beside an 8-bit core, SFR and I/O RAM bus
// Assumes: core marks machine cycles, instruction ends and return opcodes
// Notes:   serial flags live in the serial channels and are not cleared here
`timescale 1ns/1ps
module mic_intc (
	input  wire logic                  clk,
	input  wire logic                  nrst,
	input  wire logic                  sync_clr,
	input  wire mic_pkg::mic_sfr_req_t sfr,
	input  wire mic_pkg::mic_io_req_t  io,
	input  wire mic_pkg::mic_core_t    core,
	input  wire mic_pkg::mic_src_t     src,
	input  wire logic                  ext0_pin,
	input  wire logic                  ext1_pin,
	output logic                       irq_call,
	output logic [15:0]                irq_vector,
	output logic                       timer0_service_ack,
	output logic                       timer1_service_ack,
	output logic [7:0]                 sfr_rdata,
	output logic [7:0]                 io_rdata
);
	logic [7:0] timer_ext_int_control_r, timer_ext_int_control_nxt, int_enable_primary_r, int_enable_primary_nxt, int_enable_external_high_r, int_enable_external_high_nxt;
	logic [7:0] int_enable_second_serial_r, int_enable_second_serial_nxt, ip0_r, ip0_nxt, ip1_r, ip1_nxt;
	logic [7:0] ext_int_request_flags_r, ext_int_request_flags_nxt, edge_polarity_control_r, edge_polarity_control_nxt;
	logic [7:0] subf_a_r, subf_a_nxt, subf_b_r, subf_b_nxt;
	logic [7:0] suben_a_r, suben_a_nxt, suben_b_r, suben_b_nxt;
	logic [7:0] set_a, set_b;
	logic [2:0] vs_prev_r;
	logic [mic_pkg::NSRC-1:0] samp_r, samp_nxt, req_now, en_vec, pend;
	logic [mic_pkg::NLVL-1:0] active_r, active_nxt;
	logic blk_r, blk_nxt, wr_int, block, take, found;
	logic [1:0] best_lvl, cur_lvl, lv;
	logic [3:0] best_idx, irq_idx_r;
	logic [1:0] pin_lvl, pin_fall;
	logic [mic_pkg::NRAW-1:0] raw_rise, raw_fall;
	logic [3:0] line_rise, line_fall;
	logic l2_src, l5_src, l6_src;
	logic [5:1] ext_set;
	logic call_r, t0_ack_r, t1_ack_r;
	logic [15:0] vec_r;
	logic [7:0] sfr_rd_r, sfr_rd_nxt, io_rd_r, io_rd_nxt;

	// pins cross into the clock domain; internal lines do not
	mic_edge #(.W(2), .SYNC(1'b1), .IDLE(1'b1)) u_pin (
		.d     ({ext1_pin, ext0_pin}),
		.clk   (clk),
		.nrst  (nrst),
		.level (pin_lvl),
		.rise  (),
		.fall  (pin_fall)
	);
	// raw: 0 x,1 y,2 w,3 v,4 memory busy,5 port,6 transfer_busy,7 s,8 m,9 temp
	mic_edge #(.W(mic_pkg::NRAW), .SYNC(1'b0), .IDLE(1'b0)) u_raw (
		.d     (src.raw),
		.clk   (clk),
		.nrst  (nrst),
		.level (),
		.rise  (raw_rise),
		.fall  (raw_fall)
	);
	mic_edge #(.W(4), .SYNC(1'b0), .IDLE(1'b0)) u_line (
		.d     ({l6_src, l5_src, src.compute_busy, l2_src}),
		.clk   (clk),
		.nrst  (nrst),
		.level (),
		.rise  (line_rise),
		.fall  (line_fall)
	);

	// sub-source gating
	always_comb begin
		l2_src = |(subf_a_r[6:5] & suben_a_r[6:5])
			| (subf_b_r[4] & suben_b_r[6]) | (subf_b_r[3] & suben_b_r[5]);
		l5_src = (subf_a_r[7] & suben_a_r[7])
			| (subf_b_r[7] & suben_b_r[7]);
		l6_src = |(subf_a_r[2:0] & suben_a_r[2:0])
			| (subf_a_r[4] & suben_a_r[4]);
		// memory busy and transfer busy count on their fall
		set_a = {raw_fall[4], raw_rise[0], raw_rise[1], raw_rise[9],
			1'b0, raw_rise[8], raw_rise[7], raw_fall[6]};
		set_b = {raw_rise[5], 2'b00, raw_rise[2], raw_rise[3], 3'b000};
		// line 2 pulses, line 3 busy, line 4 voltage change
		ext_set[1] = edge_polarity_control_r[mic_pkg::T2_POL2] ? line_rise[0] : line_fall[0];
		ext_set[2] = edge_polarity_control_r[mic_pkg::T2_POL3] ? line_rise[1] : line_fall[1];
		ext_set[3] = |(src.voltage_status ^ vs_prev_r);
		ext_set[4] = line_rise[2];
		ext_set[5] = line_rise[3];
		// vectors in polling order
		req_now = {ext_int_request_flags_r[5], ext_int_request_flags_r[4], src.serial0_req, ext_int_request_flags_r[3],
			timer_ext_int_control_r[mic_pkg::TC_TF1], ext_int_request_flags_r[2], timer_ext_int_control_r[mic_pkg::TC_IE1],
			ext_int_request_flags_r[1], timer_ext_int_control_r[mic_pkg::TC_TF0], src.serial1_req,
			timer_ext_int_control_r[mic_pkg::TC_IE0]};
		en_vec = {int_enable_external_high_r[5], int_enable_external_high_r[4], int_enable_primary_r[4], int_enable_external_high_r[3], int_enable_primary_r[3],
			int_enable_external_high_r[2], int_enable_primary_r[2], int_enable_external_high_r[1], int_enable_primary_r[1], int_enable_second_serial_r[0],
			int_enable_primary_r[0]};
	end

	// arbitration
	always_comb begin
		pend     = samp_r & en_vec;
		found    = 1'b0;
		best_lvl = 2'b00;
		best_idx = 4'h0;
		lv       = 2'b00;
		cur_lvl  = 2'b00;
		for (int i = 0; i < mic_pkg::NSRC; i++) begin
			lv = {ip1_r[i / 2], ip0_r[i / 2]};
			// strict compare keeps the earlier source on a tie
			if (pend[i] && (!found || lv > best_lvl)) begin
				found    = 1'b1;
				best_lvl = lv;
				best_idx = 4'(i);
			end
		end
		for (int l = 0; l < mic_pkg::NLVL; l++) begin
			if (active_r[l]) begin
				cur_lvl = 2'(l);
			end
		end
		wr_int = sfr.wr && (sfr.addr == mic_pkg::SFR_INT_ENABLE_PRIMARY
			|| sfr.addr == mic_pkg::SFR_INT_ENABLE_EXTERNAL_HIGH || sfr.addr == mic_pkg::SFR_INT_ENABLE_SECOND_SERIAL
			|| sfr.addr == mic_pkg::SFR_IP0 || sfr.addr == mic_pkg::SFR_IP1);
		block = core.is_return_from_interrupt | blk_r | wr_int;
		take  = core.instr_end & int_enable_primary_r[mic_pkg::INT_ENABLE_PRIMARY_GIE] & found
			& (~|active_r | (best_lvl > cur_lvl)) & ~block;
	end

	// registers, flags and service state
	always_comb begin
		timer_ext_int_control_nxt    = timer_ext_int_control_r;
		int_enable_primary_nxt    = int_enable_primary_r;
		int_enable_external_high_nxt    = int_enable_external_high_r;
		int_enable_second_serial_nxt    = int_enable_second_serial_r;
		ip0_nxt     = ip0_r;
		ip1_nxt     = ip1_r;
		ext_int_request_flags_nxt   = ext_int_request_flags_r;
		edge_polarity_control_nxt   = edge_polarity_control_r;
		subf_a_nxt  = subf_a_r;
		subf_b_nxt  = subf_b_r;
		suben_a_nxt = suben_a_r;
		suben_b_nxt = suben_b_r;
		samp_nxt    = core.mcycle ? req_now : samp_r;
		active_nxt  = active_r;
		blk_nxt     = (blk_r | wr_int) & ~core.instr_end;
		// byte writes only; a bit op is a read then a full write
		if (sfr.wr) begin
			unique case (sfr.addr)
				mic_pkg::SFR_TIMER_EXT_INT_CONTROL:  timer_ext_int_control_nxt = sfr.wdata;
				mic_pkg::SFR_INT_ENABLE_PRIMARY:  int_enable_primary_nxt = sfr.wdata & mic_pkg::MASK_INT_ENABLE_PRIMARY;
				mic_pkg::SFR_INT_ENABLE_EXTERNAL_HIGH:  int_enable_external_high_nxt = sfr.wdata & mic_pkg::MASK_INT_ENABLE_EXTERNAL_HIGH;
				mic_pkg::SFR_INT_ENABLE_SECOND_SERIAL:  int_enable_second_serial_nxt = sfr.wdata & mic_pkg::MASK_INT_ENABLE_SECOND_SERIAL;
				mic_pkg::SFR_IP0:   ip0_nxt = sfr.wdata & mic_pkg::MASK_IP;
				mic_pkg::SFR_IP1:   ip1_nxt = sfr.wdata & mic_pkg::MASK_IP;
				mic_pkg::SFR_EXT_INT_REQUEST_FLAGS: ext_int_request_flags_nxt = sfr.wdata & mic_pkg::MASK_EXT_INT_REQUEST_FLAGS;
				mic_pkg::SFR_EDGE_POLARITY_CONTROL: edge_polarity_control_nxt = sfr.wdata & mic_pkg::MASK_EDGE_POLARITY_CONTROL;
				// written ones leave a flag alone
				mic_pkg::SFR_SUBF_A: subf_a_nxt = subf_a_r & sfr.wdata;
				mic_pkg::SFR_SUBF_B: subf_b_nxt = subf_b_r & sfr.wdata;
				default: ;
			endcase
		end
		if (io.wr && io.addr == mic_pkg::IO_SUBEN_A) begin
			suben_a_nxt = io.wdata & mic_pkg::MASK_SUBF_A;
		end
		if (io.wr && io.addr == mic_pkg::IO_SUBEN_B) begin
			suben_b_nxt = io.wdata & mic_pkg::MASK_SUBEN_B;
		end
		if (take) begin
			samp_nxt[best_idx]   = 1'b0;
			active_nxt[best_lvl] = 1'b1;
			unique case (best_idx)
				mic_pkg::SRC_T0:   timer_ext_int_control_nxt[mic_pkg::TC_TF0] = 1'b0;
				mic_pkg::SRC_T1:   timer_ext_int_control_nxt[mic_pkg::TC_TF1] = 1'b0;
				mic_pkg::SRC_EXT0: timer_ext_int_control_nxt[mic_pkg::TC_IE0] = 1'b0;
				mic_pkg::SRC_EXT1: timer_ext_int_control_nxt[mic_pkg::TC_IE1] = 1'b0;
				mic_pkg::SRC_EXT2: ext_int_request_flags_nxt[1] = 1'b0;
				mic_pkg::SRC_EXT3: ext_int_request_flags_nxt[2] = 1'b0;
				mic_pkg::SRC_EXT4: ext_int_request_flags_nxt[3] = 1'b0;
				mic_pkg::SRC_EXT5: ext_int_request_flags_nxt[4] = 1'b0;
				mic_pkg::SRC_EXT6: ext_int_request_flags_nxt[5] = 1'b0;
				default: ;
			endcase
		end
		if (core.instr_end && core.is_return_from_interrupt && |active_r) begin
			active_nxt[cur_lvl] = 1'b0;
		end
		// sets follow the write and service clears so a racing event beats them; only sync_clr overrides a set
		timer_ext_int_control_nxt[mic_pkg::TC_TF0] = timer_ext_int_control_nxt[mic_pkg::TC_TF0] | src.timer0_ovf;
		timer_ext_int_control_nxt[mic_pkg::TC_TF1] = timer_ext_int_control_nxt[mic_pkg::TC_TF1] | src.timer1_ovf;
		timer_ext_int_control_nxt[mic_pkg::TC_IE0] = timer_ext_int_control_nxt[mic_pkg::TC_IE0]
			| (timer_ext_int_control_r[mic_pkg::TC_IT0] ? pin_fall[0] : ~pin_lvl[0]);
		timer_ext_int_control_nxt[mic_pkg::TC_IE1] = timer_ext_int_control_nxt[mic_pkg::TC_IE1]
			| (timer_ext_int_control_r[mic_pkg::TC_IT1] ? pin_fall[1] : ~pin_lvl[1]);
		ext_int_request_flags_nxt[5:1] = ext_int_request_flags_nxt[5:1] | ext_set;
		subf_a_nxt = subf_a_nxt | set_a;
		subf_b_nxt = subf_b_nxt | set_b;
		if (sync_clr) begin
			timer_ext_int_control_nxt    = mic_pkg::RST_BYTE;
			int_enable_primary_nxt    = mic_pkg::RST_BYTE;
			int_enable_external_high_nxt    = mic_pkg::RST_BYTE;
			int_enable_second_serial_nxt    = mic_pkg::RST_BYTE;
			ip0_nxt     = mic_pkg::RST_BYTE;
			ip1_nxt     = mic_pkg::RST_BYTE;
			ext_int_request_flags_nxt   = mic_pkg::RST_BYTE;
			edge_polarity_control_nxt   = mic_pkg::RST_BYTE;
			subf_a_nxt  = mic_pkg::RST_BYTE;
			subf_b_nxt  = mic_pkg::RST_BYTE;
			suben_a_nxt = mic_pkg::RST_BYTE;
			suben_b_nxt = mic_pkg::RST_BYTE;
			samp_nxt    = '0;
			active_nxt  = '0;
			blk_nxt     = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			timer_ext_int_control_r    <= mic_pkg::RST_BYTE;
			int_enable_primary_r    <= mic_pkg::RST_BYTE;
			int_enable_external_high_r    <= mic_pkg::RST_BYTE;
			int_enable_second_serial_r    <= mic_pkg::RST_BYTE;
			ip0_r     <= mic_pkg::RST_BYTE;
			ip1_r     <= mic_pkg::RST_BYTE;
			ext_int_request_flags_r   <= mic_pkg::RST_BYTE;
			edge_polarity_control_r   <= mic_pkg::RST_BYTE;
			subf_a_r  <= mic_pkg::RST_BYTE;
			subf_b_r  <= mic_pkg::RST_BYTE;
			suben_a_r <= mic_pkg::RST_BYTE;
			suben_b_r <= mic_pkg::RST_BYTE;
			vs_prev_r <= 3'h0;
			samp_r    <= '0;
			active_r  <= '0;
			blk_r     <= 1'b0;
		end else begin
			timer_ext_int_control_r    <= timer_ext_int_control_nxt;
			int_enable_primary_r    <= int_enable_primary_nxt;
			int_enable_external_high_r    <= int_enable_external_high_nxt;
			int_enable_second_serial_r    <= int_enable_second_serial_nxt;
			ip0_r     <= ip0_nxt;
			ip1_r     <= ip1_nxt;
			ext_int_request_flags_r   <= ext_int_request_flags_nxt;
			edge_polarity_control_r   <= edge_polarity_control_nxt;
			subf_a_r  <= subf_a_nxt;
			subf_b_r  <= subf_b_nxt;
			suben_a_r <= suben_a_nxt;
			suben_b_r <= suben_b_nxt;
			vs_prev_r <= src.voltage_status;
			samp_r    <= samp_nxt;
			active_r  <= active_nxt;
			blk_r     <= blk_nxt;
		end
	end

	// read data; unmapped addresses answer zero
	always_comb begin
		sfr_rd_nxt = sfr_rd_r;
		io_rd_nxt  = io_rd_r;
		if (sfr.rd) begin
			unique case (sfr.addr)
				mic_pkg::SFR_TIMER_EXT_INT_CONTROL:   sfr_rd_nxt = timer_ext_int_control_r;
				mic_pkg::SFR_INT_ENABLE_PRIMARY:   sfr_rd_nxt = int_enable_primary_r;
				mic_pkg::SFR_INT_ENABLE_EXTERNAL_HIGH:   sfr_rd_nxt = int_enable_external_high_r;
				mic_pkg::SFR_INT_ENABLE_SECOND_SERIAL:   sfr_rd_nxt = int_enable_second_serial_r;
				mic_pkg::SFR_IP0:    sfr_rd_nxt = ip0_r;
				mic_pkg::SFR_IP1:    sfr_rd_nxt = ip1_r;
				mic_pkg::SFR_EXT_INT_REQUEST_FLAGS:  sfr_rd_nxt = ext_int_request_flags_r;
				mic_pkg::SFR_EDGE_POLARITY_CONTROL:  sfr_rd_nxt = edge_polarity_control_r;
				mic_pkg::SFR_SUBF_A: sfr_rd_nxt = subf_a_r;
				mic_pkg::SFR_SUBF_B: sfr_rd_nxt = subf_b_r;
				default:             sfr_rd_nxt = 8'h00;
			endcase
		end
		if (io.rd) begin
			if (io.addr == mic_pkg::IO_SUBEN_A) begin
				io_rd_nxt = suben_a_r;
			end else if (io.addr == mic_pkg::IO_SUBEN_B) begin
				io_rd_nxt = suben_b_r;
			end else begin
				io_rd_nxt = 8'h00;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			call_r    <= 1'b0;
			vec_r     <= 16'h0000;
			irq_idx_r <= 4'h0;
			t0_ack_r  <= 1'b0;
			t1_ack_r  <= 1'b0;
			sfr_rd_r  <= 8'h00;
			io_rd_r   <= 8'h00;
		end else begin
			call_r    <= take;
			vec_r     <= take ? mic_pkg::VEC_TAB[best_idx] : vec_r;
			irq_idx_r <= take ? best_idx : irq_idx_r;
			t0_ack_r  <= take && best_idx == mic_pkg::SRC_T0;
			t1_ack_r  <= take && best_idx == mic_pkg::SRC_T1;
			sfr_rd_r  <= sfr_rd_nxt;
			io_rd_r   <= io_rd_nxt;
		end
	end

	assign irq_call           = call_r;
	assign irq_vector         = vec_r;
	assign timer0_service_ack = t0_ack_r;
	assign timer1_service_ack = t1_ack_r;
	assign sfr_rdata          = sfr_rd_r;
	assign io_rdata           = io_rd_r;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	a_global_gate: assert property (
		irq_call |-> $past(int_enable_primary_r[mic_pkg::INT_ENABLE_PRIMARY_GIE]))
		else $error("call taken with global enable low");
	a_call_enabled: assert property (
		irq_call |-> $past(|(samp_r & en_vec)))
		else $error("call without an enabled sampled request");
	a_no_call_block: assert property (
		$past(core.is_return_from_interrupt) || $past(wr_int) |-> !irq_call)
		else $error("call during return or enable write");
	a_vector_map: assert property (
		irq_call |-> irq_vector == mic_pkg::VEC_TAB[irq_idx_r])
		else $error("vector does not match source");
	a_t0_ack_clr: assert property (
		timer0_service_ack && !$past(src.timer0_ovf)
		|-> !timer_ext_int_control_r[mic_pkg::TC_TF0])
		else $error("timer0 flag survived acknowledge");
	a_preempt_only: assert property (
		irq_call && $past(|active_r) |-> $past(best_lvl) > $past(cur_lvl))
		else $error("equal or lower priority preempted");
	a_subflag_ones: assert property (
		$past(sfr.wr && sfr.addr == mic_pkg::SFR_SUBF_A)
		|-> ((subf_a_r & ~$past(subf_a_r)) & ~$past(set_a)) == 8'h00)
		else $error("written one set a sub flag");
	a_return_from_interrupt_level: assert property (
		$past(core.instr_end && core.is_return_from_interrupt && |active_r && !sync_clr)
		|-> $countones(active_r) == $countones($past(active_r)) - 1)
		else $error("return did not end one level");
	a_flag_sets: assert property (
		$past(ext_set[1] && !sync_clr) |-> ##[0:2] ext_int_request_flags_r[1])
		else $error("line 2 event lost");
	c_call: cover property (irq_call);
	c_nested: cover property (irq_call && $past(|active_r));
	c_return_from_interrupt: cover property (core.instr_end && core.is_return_from_interrupt && |active_r);
	c_tie: cover property (take && $countones(pend) > 1);
endmodule

// ===== include/mic_pkg.sv
// Purpose: shared constants and carriers for the interrupt controller
// Assumes: byte-wide special function register bus from the core
// Notes:   source index order equals the fixed polling order
package mic_pkg;
	localparam int NSRC = 11;
	localparam int NLVL = 4;
	localparam int NRAW = 10;
	// register offsets
	localparam logic [7:0] SFR_TIMER_EXT_INT_CONTROL   = 8'h88;
	localparam logic [7:0] SFR_INT_ENABLE_SECOND_SERIAL   = 8'h9a;
	localparam logic [7:0] SFR_INT_ENABLE_PRIMARY   = 8'ha8;
	localparam logic [7:0] SFR_IP0    = 8'ha9;
	localparam logic [7:0] SFR_INT_ENABLE_EXTERNAL_HIGH   = 8'hb8;
	localparam logic [7:0] SFR_IP1    = 8'hb9;
	localparam logic [7:0] SFR_EXT_INT_REQUEST_FLAGS  = 8'hc0;
	localparam logic [7:0] SFR_EDGE_POLARITY_CONTROL  = 8'hc8;
	localparam logic [7:0] SFR_SUBF_A = 8'he8;
	localparam logic [7:0] SFR_SUBF_B = 8'hf8;
	localparam logic [15:0] IO_SUBEN_A = 16'h2700;
	localparam logic [15:0] IO_SUBEN_B = 16'h2701;
	localparam logic [7:0] RST_BYTE   = 8'h00;
	// implemented bits of each register
	localparam logic [7:0] MASK_INT_ENABLE_PRIMARY   = 8'hdf;
	localparam logic [7:0] MASK_INT_ENABLE_EXTERNAL_HIGH   = 8'h3e;
	localparam logic [7:0] MASK_INT_ENABLE_SECOND_SERIAL   = 8'h01;
	localparam logic [7:0] MASK_IP     = 8'h3f;
	localparam logic [7:0] MASK_EXT_INT_REQUEST_FLAGS  = 8'h3e;
	localparam logic [7:0] MASK_EDGE_POLARITY_CONTROL  = 8'h60;
	localparam logic [7:0] MASK_SUBF_A = 8'hf7;
	localparam logic [7:0] MASK_SUBF_B = 8'h98;
	localparam logic [7:0] MASK_SUBEN_B = 8'he0;
	// field positions
	localparam int TC_TF1 = 7;
	localparam int TC_TF0 = 5;
	localparam int TC_IE1 = 3;
	localparam int TC_IT1 = 2;
	localparam int TC_IE0 = 1;
	localparam int TC_IT0 = 0;
	localparam int INT_ENABLE_PRIMARY_GIE = 7;
	localparam int T2_POL2 = 5;
	localparam int T2_POL3 = 6;
	// source indices in polling order
	localparam logic [3:0] SRC_EXT0 = 4'h0;
	localparam logic [3:0] SRC_SER1 = 4'h1;
	localparam logic [3:0] SRC_T0   = 4'h2;
	localparam logic [3:0] SRC_EXT2 = 4'h3;
	localparam logic [3:0] SRC_EXT1 = 4'h4;
	localparam logic [3:0] SRC_EXT3 = 4'h5;
	localparam logic [3:0] SRC_T1   = 4'h6;
	localparam logic [3:0] SRC_EXT4 = 4'h7;
	localparam logic [3:0] SRC_SER0 = 4'h8;
	localparam logic [3:0] SRC_EXT5 = 4'h9;
	localparam logic [3:0] SRC_EXT6 = 4'ha;
	localparam logic [NSRC-1:0][15:0] VEC_TAB = {
		16'h006b, 16'h0063, 16'h0023, 16'h005b, 16'h001b, 16'h0053,
		16'h0013, 16'h004b, 16'h000b, 16'h0083, 16'h0003};
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} mic_sfr_req_t;
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} mic_io_req_t;
	typedef struct packed {
		logic mcycle;
		logic instr_end;
		logic is_return_from_interrupt;
	} mic_core_t;
	typedef struct packed {
		logic       timer0_ovf;
		logic       timer1_ovf;
		logic       serial0_req;
		logic       serial1_req;
		logic       compute_busy;
		logic [2:0] voltage_status;
		logic [NRAW-1:0] raw;
	} mic_src_t;
endpackage
